// *** rbb_pkg.sv ***
/*
 * shared constants, codes and carriers of the receive baseband block.
 * assumes a 200 MHz reference clock and a 12.8 MHz crystal time base.
 */
package rbb_pkg;

    // ==========================================================
    // time base
    localparam int               REF_KHZ      = 200000;
    localparam int               XTAL_KHZ     = 12800;
    localparam int               ACC_W        = 18;
    localparam logic [ACC_W-1:0] ACC_MOD      = ACC_W'(REF_KHZ);
    localparam logic [ACC_W-1:0] ACC_STEP     = ACC_W'(XTAL_KHZ);
    localparam logic [7:0]       SUB_PER_BIT  = 8'h10; // sixteenths of a bit
    localparam logic [3:0]       PHASE_SAMPLE = 4'h8;  // bit centre
    localparam logic [3:0]       PHASE_EDGE   = 4'h0;  // bit boundary
    localparam logic [4:0]       PREAMBLE_END = 5'h17; // 24 alternating bits

    // ==========================================================
    // threshold tracking, half-dB units
    localparam logic [7:0]  PEAK_OFFSET = 8'h0c; // 6 dB
    localparam logic [63:0] STEP_TABLE  = 64'h0c0a_0806_0403_0201;
    localparam logic [3:0]  AVG_SHIFT_FAST = 4'h6;
    localparam logic [3:0]  AVG_SHIFT_MID  = 4'h7;
    localparam logic [3:0]  AVG_SHIFT_SLOW = 4'h8;
    localparam logic [1:0]  THR_PEAK  = 2'h0;
    localparam logic [1:0]  THR_FIXED = 2'h1;
    localparam logic [1:0]  THR_AVG   = 2'h2;

    // ==========================================================
    // modes and selects
    localparam logic [1:0] CHIP_STANDBY = 2'h0;
    localparam logic [1:0] CHIP_RX      = 2'h1;
    localparam logic [1:0] CHIP_TX      = 2'h2;
    localparam logic [1:0] DMODE_CONT   = 2'h0;
    localparam int         QUEUE_DEPTH  = 64;
    localparam logic [1:0] IRQ_SEL0     = 2'h0;
    localparam logic [1:0] IRQ_SEL1     = 2'h1;
    localparam logic [1:0] IRQ_SEL2     = 2'h2;

    typedef enum logic [1:0] {
        RBB_HUNT   = 2'b01,
        RBB_LOCKED = 2'b10
    } rbb_lock_e;

    typedef struct packed {
        logic [1:0] chip_mode;
        logic [1:0] data_mode;
        logic [1:0] threshold_mode_select;
        logic [2:0] threshold_decay_rate;
        logic [2:0] threshold_decay_step;
        logic [7:0] fixed_threshold_value;
        logic [7:0] floor_threshold_value;
        logic [1:0] average_cutoff_select;
        logic [6:0] bit_rate_divider;
        logic       synchronizer_disable_bit;
        logic [1:0] queue_size_select;
        logic [5:0] queue_threshold;
        logic [1:0] irq_a_select;
        logic [1:0] irq_b_select;
    } rbb_cfg_s;

    typedef struct packed {
        logic [ACC_W-1:0] xacc;
        logic [8:0]       subcnt;
        logic [7:0]       decay_cnt;
        logic [7:0]       peak;
        logic [15:0]      avg;
        logic             comp;
        logic             prev_comp;
        logic [3:0]       phase;
        logic             recovered_data_clock;
        logic             rbit;
        logic [4:0]       pre_cnt;
        rbb_lock_e        lock;
        logic             data_out;
        logic [7:0]       sr;
        logic [2:0]       bitcnt;
        logic             filling;
        logic             bw;
        logic [5:0]       wptr;
        logic [5:0]       rptr;
        logic [6:0]       count;
        logic             ovr;
        logic [7:0]       rd_byte;
        logic             csn_prev;
        logic [1:0]       mode_prev;
        logic [7:0]       tx_sr;
        logic [2:0]       tx_left;
        logic             tx_busy;
        logic             tx_bit;
        logic             tx_done;
        logic             irq_a;
        logic             irq_b;
        logic             irq_b_oe;
    } rbb_core_s;

endpackage

// *** rbb_sync2.sv ***
/*
 * two-flop synchroniser for pins entering the reference domain.
 * assumes an already synchronised active-low reset.
 */
`timescale 1ns/1ps
module rbb_sync2 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rbb_sync_s;

    rbb_sync_s st_reg;
    rbb_sync_s st_next;

    // first stage feeds only the second
    always_comb
    begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= {INIT, INIT};
        else
            st_reg <= st_next;
    end

    assign q = st_reg.s2;
endmodule // rbb_sync2

// *** rbb_link_tx.sv ***
/*
 * link side of the queue read port, clocked by the host serial clock.
 * assumes byte_in stands still while the chip select is low.
 */
`timescale 1ns/1ps
module rbb_link_tx (
    input  wire logic       link_clk,
    input  wire logic       data_chip_select_n,
    input  wire logic [7:0] byte_in,
    output logic            sdo
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       sdo;
    } rbb_link_s;

    rbb_link_s st_reg;
    rbb_link_s st_next;

    // msb first, one bit per rising edge
    always_comb
    begin
        st_next     = st_reg;
        st_next.sdo = byte_in[3'h7 - st_reg.cnt];
        st_next.cnt = st_reg.cnt + 3'h1;
    end

    // frame end clears the shifter; no edge needed
    always_ff @(posedge link_clk or posedge data_chip_select_n)
    begin
        if (data_chip_select_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sdo = st_reg.sdo;
endmodule // rbb_link_tx

// *** rbb_rx_baseband.sv ***
/*
 * receive baseband path: amplitude threshold, bit synchroniser,
 * receive shift register, byte queue, transmit drain, irq pins.
 * assumes config ports come from a register file on ref_clk and
 * rssi_sample from the rssi block on ref_clk.
 */
// Operation
// R1: decay rate code sets decrements per chip period, slow or fast.
// R2: decay step code sets decrement size from 0.5 to 6 dB.
// R3: fixed mode compares rssi against the fixed threshold value.
// R4: average mode low-pass filters rssi; cutoff code sets averaging length.
// R5: synchroniser bypassed only if disable bit set and line b held low.
// R6: active synchroniser in continuous mode drives recovered clock on line b. Code holds line b low until the synchroniser is locked.
// R7: synchroniser forced on in buffered and packet modes.
// R8: bit rate is crystal over 64 times one plus divider.
// R9: lock after 24 alternating bits; clock rise centred, kept by transitions.
// R10: continuous mode uses data pin; other modes deliver through the queue.
// R11: rx bits fill shift register, bytes queued only after sync found.
// R12: host should set queue threshold to at least eight bits.
// R13: queue capacity 16, 32, 48 or 64 bytes by size select.
// R14: events drive the two interrupt lines per mapping selects.
// R15: byte written source high one bit period per queued byte.
// R16: transmit complete high once queue empty and last bit sent.
// R17: full source high exactly while every queue slot is occupied.
// R18: write into full queue loses byte, sets overrun; clear empties queue.
// R19: not-empty source high while at least one byte is queued.
// R20: not-empty updates at chip select fall; host checks after each read.
// R21: threshold source compares fill level with threshold, per chip mode.
// R22: peak mode threshold is peak minus 6 dB; peak decays on zeros.
// R23: decaying threshold never falls below the floor value.
// R24: two-bit mode select chooses peak, fixed or average threshold.
// R25: queue is first in first out; pointers move only on documented events.
// R26: comparator high when rssi exceeds threshold; feeds the synchroniser.
`timescale 1ns/1ps
module rbb_rx_baseband
    import rbb_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       link_clk,
    input  wire rbb_cfg_s   cfg,
    input  wire logic [7:0] rssi_sample,
    input  wire logic       sync_pattern_found,
    input  wire logic       host_wr_valid,
    input  wire logic [7:0] host_wr_data,
    input  wire logic       overrun_clear,
    input  wire logic       data_chip_select_n,
    input  wire logic       interrupt_line_b_in,
    output logic            queue_read_data,
    output logic            interrupt_line_a,
    output logic            interrupt_line_b,
    output logic            interrupt_line_b_oe,
    output logic            data_out,
    output logic            modulator_bit,
    output logic            queue_overrun_flag,
    output logic            bit_synchronizer_locked
);

    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_pipe;
    logic       rst_n_sync;
    logic       csn_s;
    logic       line_b_s;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end

    assign rst_n_sync = rst_pipe[1];

    rbb_sync2 #(
        .W    (2),
        .INIT (2'b11)
    ) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_n_sync),
        .d     ({data_chip_select_n, interrupt_line_b_in}),
        .q     ({csn_s, line_b_s})
    );

    // ==========================================================
    // state and queue storage
    rbb_core_s  s;
    rbb_core_s  n;
    logic [7:0] mem [0:QUEUE_DEPTH-1];

    logic [ACC_W-1:0] acc_sum;
    logic             xtick;
    logic             sub_tick;
    logic [8:0]       sub_last;
    logic [7:0]       dec_last;
    logic             decay_tick;
    logic [7:0]       step;
    logic [3:0]       avg_k;
    logic signed [16:0] avg_diff;
    logic signed [16:0] avg_delta;
    logic [16:0]      avg_sum;
    logic [7:0]       thr_peak;
    logic [7:0]       thr;
    logic             cont;
    logic             bypass;
    logic [3:0]       ph_next;
    logic             bit_sample;
    logic             bit_edge;
    logic             in_rx;
    logic             in_tx;
    logic             push_rx;
    logic             push_host;
    logic             push_ok;
    logic [7:0]       push_data;
    logic             pop;
    logic             q_clear;
    logic [6:0]       cap;
    logic [5:0]       cap_last;
    logic             full;
    logic             full_n;
    logic             thr_src;

    rbb_link_tx u_link (
        .link_clk           (link_clk),
        .data_chip_select_n (data_chip_select_n),
        .byte_in            (s.rd_byte),
        .sdo                (queue_read_data)
    );

    always_comb
    begin
        n          = s;
        xtick      = 1'b0;
        sub_tick   = 1'b0;
        bit_sample = 1'b0;
        bit_edge   = 1'b0;
        push_rx    = 1'b0;
        pop        = 1'b0;
        cont       = (cfg.data_mode == DMODE_CONT);
        in_rx      = (cfg.chip_mode == CHIP_RX);
        in_tx      = (cfg.chip_mode == CHIP_TX);
        // disable bit plus line b held low, continuous only
        bypass     = cont & cfg.synchronizer_disable_bit & ~line_b_s; // R5 R7

        // ======================================================
        // crystal time base: sixteen sub ticks per bit
        acc_sum = s.xacc + ACC_STEP;
        if (acc_sum >= ACC_MOD)
        begin
            n.xacc = acc_sum - ACC_MOD;
            xtick  = 1'b1;
        end
        else
            n.xacc = acc_sum;
        sub_last = {cfg.bit_rate_divider, 2'b11}; // R8
        if (xtick)
        begin
            if (s.subcnt == sub_last)
            begin
                n.subcnt = '0;
                sub_tick = 1'b1;
            end
            else
                n.subcnt = s.subcnt + 9'h001;
        end

        // ======================================================
        // peak decay cadence and step
        if (cfg.threshold_decay_rate[2])
            dec_last = (SUB_PER_BIT >> (3'h1 + cfg.threshold_decay_rate[1:0])) - 8'h01; // R1
        else
            dec_last = (SUB_PER_BIT << cfg.threshold_decay_rate[1:0]) - 8'h01; // R1
        decay_tick = sub_tick & (s.decay_cnt == dec_last);
        if (sub_tick)
            n.decay_cnt = decay_tick ? 8'h00 : s.decay_cnt + 8'h01;
        step = STEP_TABLE[{cfg.threshold_decay_step, 3'b000} +: 8]; // R2

        // peak follows rssi up, decays on zeros down to floor
        if (rssi_sample > s.peak)
            n.peak = rssi_sample;
        else if (decay_tick & ~s.comp)
        begin
            if ({1'b0, s.peak} >= {1'b0, cfg.floor_threshold_value} + {1'b0, step})
                n.peak = s.peak - step; // R22
            else
                n.peak = cfg.floor_threshold_value; // R23
        end
        if (s.peak > PEAK_OFFSET && s.peak - PEAK_OFFSET > cfg.floor_threshold_value)
            thr_peak = s.peak - PEAK_OFFSET; // R22
        else
            thr_peak = cfg.floor_threshold_value; // R23

        // ======================================================
        // running average of rssi, 8 fraction bits
        unique case (cfg.average_cutoff_select)
            2'b00:   avg_k = AVG_SHIFT_FAST; // R4
            2'b11:   avg_k = AVG_SHIFT_SLOW; // R4
            default: avg_k = AVG_SHIFT_MID;
        endcase
        avg_diff  = $signed({1'b0, rssi_sample, 8'h00}) - $signed({1'b0, s.avg});
        avg_delta = avg_diff >>> avg_k;
        avg_sum   = {1'b0, s.avg} + $unsigned(avg_delta);
        if (sub_tick)
            n.avg = avg_sum[15:0]; // R4

        // threshold choice and comparator
        unique case (cfg.threshold_mode_select) // R24
            THR_FIXED: thr = cfg.fixed_threshold_value; // R3
            THR_AVG:   thr = s.avg[15:8]; // R4
            default:   thr = thr_peak;
        endcase
        n.comp = (rssi_sample > thr); // R26

        // ======================================================
        // bit synchroniser: edges pull boundary toward phase 0
        ph_next = s.phase;
        if (sub_tick)
        begin
            n.prev_comp = s.comp;
            ph_next     = s.phase + 4'h1;
            if (s.comp != s.prev_comp)
            begin
                if (s.phase[3])
                    ph_next = s.phase + 4'h2; // R9
                else if (s.phase != PHASE_EDGE)
                    ph_next = s.phase; // R9
            end
            bit_sample = (ph_next == PHASE_SAMPLE);
            bit_edge   = (ph_next == PHASE_EDGE);
        end
        n.phase = ph_next;
        n.recovered_data_clock  = ph_next[3]; // R9

        // preamble hunt: 24 alternating bits give lock
        if (bit_sample)
        begin
            n.rbit    = s.comp;
            n.pre_cnt = (s.comp != s.rbit) ? s.pre_cnt + 5'h01 : 5'h00;
            if (s.lock == RBB_HUNT && s.comp != s.rbit && s.pre_cnt == PREAMBLE_END)
                n.lock = RBB_LOCKED; // R9
        end
        if (!in_rx || bypass)
        begin
            n.lock    = RBB_HUNT;
            n.pre_cnt = '0;
        end

        // ======================================================
        // data pin: raw when bypassed, cleaned at bit boundary
        if (!cont)
            n.data_out = 1'b0; // R10
        else if (bypass)
            n.data_out = s.comp; // R5
        else if (bit_edge)
            n.data_out = (s.lock == RBB_LOCKED) & s.rbit; // R10

        // ======================================================
        // receive shift register, queued after sync found
        if (in_rx && !cont && s.lock == RBB_LOCKED && sync_pattern_found)
            n.filling = 1'b1; // R11
        if (bit_sample && s.filling)
        begin
            n.sr     = {s.sr[6:0], s.comp}; // R11
            n.bitcnt = s.bitcnt + 3'h1;
            push_rx  = (s.bitcnt == 3'h7);
        end
        if (!in_rx || cont)
        begin
            n.filling = 1'b0;
            n.bitcnt  = '0;
        end
        // byte written: one bit period, set wins
        if (push_rx)
            n.bw = 1'b1; // R15
        else if (bit_sample)
            n.bw = 1'b0; // R15

        // ======================================================
        // queue bookkeeping
        cap       = {3'({1'b0, cfg.queue_size_select} + 3'h1), 4'h0}; // R13
        cap_last  = {cfg.queue_size_select, 4'hf}; // R13
        full      = (s.count == cap); // R17
        push_host = host_wr_valid & ~in_rx & ~cont;
        push_data = push_rx ? {s.sr[6:0], s.comp} : host_wr_data;
        push_ok   = (push_rx | push_host) & ~full; // R18
        n.csn_prev = csn_s;

        // read pops at chip select fall
        if (s.csn_prev && !csn_s && s.count != '0)
        begin
            n.rd_byte = mem[s.rptr]; // R20 R25
            pop       = 1'b1;
        end

        // transmit drain at each bit boundary
        if (in_tx && !cont && bit_edge)
        begin
            if (s.tx_left != '0)
            begin
                n.tx_bit  = s.tx_sr[7];
                n.tx_sr   = {s.tx_sr[6:0], 1'b0};
                n.tx_left = s.tx_left - 3'h1;
            end
            else if (s.count != '0 && !pop)
            begin
                n.tx_bit  = mem[s.rptr][7];
                n.tx_sr   = {mem[s.rptr][6:0], 1'b0};
                n.tx_left = 3'h7;
                n.tx_busy = 1'b1;
                pop       = 1'b1;
            end
            else if (s.tx_busy)
                n.tx_done = 1'b1; // R16
        end
        if (!in_tx || push_host)
        begin
            n.tx_done = 1'b0;
            n.tx_busy = in_tx & s.tx_busy;
        end
        if (!in_tx)
            n.tx_left = '0;

        // pointers and fill level
        if (push_ok)
            n.wptr = (s.wptr == cap_last) ? 6'h00 : s.wptr + 6'h01; // R25
        if (pop)
            n.rptr = (s.rptr == cap_last) ? 6'h00 : s.rptr + 6'h01; // R25
        n.count = s.count + {6'h00, push_ok} - {6'h00, pop};

        // overrun: set wins over clear; clear also empties
        n.mode_prev = cfg.chip_mode;
        q_clear     = overrun_clear | (in_rx & (s.mode_prev != CHIP_RX));
        if (q_clear)
        begin
            n.wptr  = '0; // R18
            n.rptr  = '0;
            n.count = '0;
            n.ovr   = s.ovr & ~overrun_clear; // R18
        end
        if ((push_rx | push_host) & full)
            n.ovr = 1'b1; // R18

        // ======================================================
        // interrupt lines from next-state sources
        full_n = (n.count == cap);
        if (in_tx)
            thr_src = (n.count <= {1'b0, cfg.queue_threshold}); // R21
        else
            thr_src = (n.count >= {1'b0, cfg.queue_threshold}); // R21
        unique case (cfg.irq_a_select) // R14
            IRQ_SEL0: n.irq_a = n.bw; // R15
            IRQ_SEL1: n.irq_a = (n.count != '0); // R19
            IRQ_SEL2: n.irq_a = thr_src;
            default:  n.irq_a = full_n; // R17
        endcase
        if (cont && !bypass)
            n.irq_b = n.recovered_data_clock & (n.lock == RBB_LOCKED); // R6
        else
        begin
            unique case (cfg.irq_b_select) // R14
                IRQ_SEL0: n.irq_b = full_n; // R17
                IRQ_SEL1: n.irq_b = n.tx_done; // R16
                IRQ_SEL2: n.irq_b = thr_src;
                default:  n.irq_b = (n.count != '0); // R19
            endcase
        end
        // release line b so the host may hold it low
        n.irq_b_oe = ~(cont & cfg.synchronizer_disable_bit); // R5
    end

    // queue storage, no reset
    always_ff @(posedge ref_clk)
    begin
        if (push_ok)
            mem[s.wptr] <= push_data;
    end

    // register the whole state
    always_ff @(posedge ref_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s          <= '0;
            s.lock     <= RBB_HUNT;
            s.csn_prev <= 1'b1;
        end
        else
            s <= n;
    end

    // ==========================================================
    // outputs straight from state flops
    assign interrupt_line_a    = s.irq_a;
    assign interrupt_line_b    = s.irq_b;
    assign interrupt_line_b_oe = s.irq_b_oe;
    assign data_out            = s.data_out;
    assign modulator_bit       = s.tx_bit;
    assign queue_overrun_flag  = s.ovr;
    assign bit_synchronizer_locked      = s.lock[1]; // one-hot locked code

endmodule // rbb_rx_baseband

// *** rbb_rx_baseband_asserts.sv ***
/* port checker for the receive baseband block; assumes cfg steady around each check. */
`timescale 1ns/1ps
module rbb_chk
    import rbb_pkg::*;
(
    input wire logic     ref_clk,
    input wire logic     rstn,
    input wire rbb_cfg_s cfg,
    input wire logic     host_wr_valid,
    input wire logic     overrun_clear,
    input wire logic     data_chip_select_n,
    input wire logic     queue_read_data,
    input wire logic     interrupt_line_a,
    input wire logic     interrupt_line_b,
    input wire logic     interrupt_line_b_oe,
    input wire logic     data_out,
    input wire logic     queue_overrun_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // host byte taken, queue flags stable in buffered mode
    sequence wr_taken;
        host_wr_valid && !overrun_clear && cfg.chip_mode != CHIP_RX
            && cfg.data_mode != DMODE_CONT;
    endsequence
    sequence flags_steady;
        cfg.data_mode != DMODE_CONT && $stable(cfg);
    endsequence
    read_idle_a: assert property (data_chip_select_n [*3] |-> !queue_read_data)
        else $error("read line not idle");
    data_quiet_a: assert property ((cfg.data_mode != DMODE_CONT) [*2] |-> !data_out)
        else $error("data pin active outside continuous mode");
    bypass_oe_a: assert property
        ((cfg.data_mode == DMODE_CONT && cfg.synchronizer_disable_bit) [*2] |-> !interrupt_line_b_oe)
        else $error("line b driven while bypassed");
    ovr_sticky_a: assert property (queue_overrun_flag && !overrun_clear |=> queue_overrun_flag)
        else $error("overrun flag dropped");
    ovr_clear_a: assert property
        (overrun_clear && !host_wr_valid && cfg.chip_mode != CHIP_RX |=> !queue_overrun_flag)
        else $error("overrun flag not cleared");
    ovr_cause_a: assert property
        ($rose(queue_overrun_flag) |-> $past(host_wr_valid) || $past(cfg.chip_mode) == CHIP_RX)
        else $error("overrun without a write");
    nonempty_set_a: assert property
        (wr_taken ##0 cfg.irq_a_select == IRQ_SEL1 |-> ##[1:2] interrupt_line_a)
        else $error("not empty missing after write");
    full_nonempty_a: assert property (flags_steady ##0 cfg.irq_b_select == IRQ_SEL0
        && cfg.irq_a_select == IRQ_SEL1 && interrupt_line_b |-> interrupt_line_a)
        else $error("full while empty");
    clear_unfull_a: assert property (flags_steady ##0 cfg.irq_b_select == IRQ_SEL0
        && interrupt_line_b && overrun_clear && !host_wr_valid |-> ##[1:2] !interrupt_line_b)
        else $error("queue not emptied by clear");
endmodule // rbb_chk
bind rbb_rx_baseband rbb_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .cfg(cfg),
    .host_wr_valid(host_wr_valid), .overrun_clear(overrun_clear),
    .data_chip_select_n(data_chip_select_n), .queue_read_data(queue_read_data),
    .interrupt_line_a(interrupt_line_a), .interrupt_line_b(interrupt_line_b),
    .interrupt_line_b_oe(interrupt_line_b_oe), .data_out(data_out),
    .queue_overrun_flag(queue_overrun_flag));

// *** rbb_host_model.sv ***
/* host side of the queue read link; assumes a 12 ns serial clock idle between frames. */
`timescale 1ns/1ps
module rbb_host_model (
    output logic      link_clk,
    output logic      data_chip_select_n,
    input  wire logic queue_read_data
);
    initial
    begin
        link_clk = 1'b0;
        data_chip_select_n = 1'b1;
    end
    // one whole frame, msb first, sampled at the falling clock edge
    task automatic rd(output logic [7:0] b);
        data_chip_select_n = 1'b0;
        #30;
        for (int i = 7; i >= 0; i--)
        begin
            link_clk = 1'b1;
            #6;
            b[i] = queue_read_data;
            link_clk = 1'b0;
            #6;
        end
        data_chip_select_n = 1'b1;
        #30;
    endtask
endmodule // rbb_host_model

// *** rbb_rx_baseband_tb_top.sv ***
/* self-checking bench: queue, overrun, threshold, bypass; assumes host model and checker. */
`timescale 1ns/1ps
module rbb_rx_baseband_tb_top
    import rbb_pkg::*;
;
    logic ref_clk, rstn, link_clk, csn, b_in;
    logic host_wr_valid = 1'b0, overrun_clear = 1'b0;
    logic rd_data, irq_a, irq_b, b_oe, dout, ovr;
    logic [7:0] host_wr_data = 8'h00, v, rssi = 8'h40;
    rbb_cfg_s cfg;
    int fail_count = 0, cmp_count = 0;
    assign b_in = b_oe ? irq_b : 1'b0;
    rbb_rx_baseband uut (.ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk), .cfg(cfg),
        .rssi_sample(rssi), .sync_pattern_found(1'b0), .host_wr_valid(host_wr_valid),
        .host_wr_data(host_wr_data), .overrun_clear(overrun_clear),
        .data_chip_select_n(csn), .interrupt_line_b_in(b_in), .queue_read_data(rd_data),
        .interrupt_line_a(irq_a), .interrupt_line_b(irq_b), .interrupt_line_b_oe(b_oe),
        .data_out(dout), .modulator_bit(), .queue_overrun_flag(ovr), .bit_synchronizer_locked());
    rbb_host_model host (.link_clk(link_clk), .data_chip_select_n(csn),
        .queue_read_data(rd_data));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // back to back host writes of base, base+1, ...
    task automatic wr(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++)
        begin
            @(negedge ref_clk);
            host_wr_valid = 1'b1;
            host_wr_data = base + 8'(i);
        end
        @(negedge ref_clk);
        host_wr_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic clr;
        @(negedge ref_clk);
        overrun_clear = 1'b1;
        @(negedge ref_clk);
        overrun_clear = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask
    initial
    begin
        #100_000;
        fail_count++;
        end_sim;
    end
    initial
    begin
        cfg = '0;
        cfg.data_mode = 2'h1;
        cfg.irq_a_select = IRQ_SEL1;
        cfg.queue_threshold = 6'h08;
        rstn = 1'b0;
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (6) @(negedge ref_clk);
        // size code 0: one short of full, full, then a lost byte
        wr(15, 8'h40);
        chk("full", 8'h00, {7'h0, irq_b});
        chk("not_empty", 8'h01, {7'h0, irq_a});
        wr(1, 8'h4f);
        chk("full", 8'h01, {7'h0, irq_b});
        wr(1, 8'hee);
        chk("overrun", 8'h01, {7'h0, ovr});
        for (int i = 0; i < 16; i++)
        begin
            host.rd(v);
            chk("byte", 8'h40 + 8'(i), v);
        end
        repeat (3) @(negedge ref_clk);
        chk("not_empty", 8'h00, {7'h0, irq_a});
        chk("full", 8'h00, {7'h0, irq_b});
        // remaining size codes, each emptied by the overrun clear
        for (int s = 1; s < 4; s++)
        begin
            cfg.queue_size_select = 2'(s);
            wr(16 * (s + 1) - 1, 8'h00);
            chk("full", 8'h00, {7'h0, irq_b});
            wr(1, 8'h00);
            chk("full", 8'h01, {7'h0, irq_b});
            clr;
            chk("full", 8'h00, {7'h0, irq_b});
            chk("not_empty", 8'h00, {7'h0, irq_a});
            chk("overrun", 8'h00, {7'h0, ovr});
        end
        // fill level against threshold in standby
        cfg.irq_a_select = IRQ_SEL2;
        wr(7, 8'h10);
        chk("threshold", 8'h00, {7'h0, irq_a});
        wr(1, 8'h17);
        chk("threshold", 8'h01, {7'h0, irq_a});
        clr;
        // continuous mode: bypass releases line b, active sync drives it
        cfg.threshold_mode_select = THR_FIXED;
        cfg.fixed_threshold_value = 8'h40;
        cfg.data_mode = DMODE_CONT;
        cfg.synchronizer_disable_bit = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("line_b_oe", 8'h00, {7'h0, b_oe});
        chk("data_raw", 8'h00, {7'h0, dout});
        rssi = 8'h41;
        repeat (4) @(negedge ref_clk);
        chk("data_raw", 8'h01, {7'h0, dout});
        cfg.synchronizer_disable_bit = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("line_b_oe", 8'h01, {7'h0, b_oe});
        end_sim;
    end
endmodule // rbb_rx_baseband_tb_top
